// ---- logic/accel_power_mode_control.sv ----
`timescale 1ns/10ps
// Functional notes
// - Power-up lands in standby, sensing off.
// - Measure bit set enters measurement mode.
// - Measure bit bit 3 cleared returns standby.
// - All registers readable and writable in standby.
// - Standby takes no acceleration measurements.
// - Standby leaves buffered samples untouched.
// - Rate code selects rate; bandwidth half.
// - Rate register bit 4 selects low power.
// - Low power reduces sampling, 12.5-400 Hz.
// - Inactivity with auto sleep and link bits set enters slow sleep.
module accel_power_mode_control #(
    parameter int BASE_PERIOD = accel_pm_pkg::BASE_PERIOD_CYC,
    parameter int CW          = 24
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Register port from the serial interface
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wr_data,
    output logic      [7:0] reg_rd_data,
    output logic            reg_rd_valid,
    // Motion detector
    input  wire logic       inact_event,
    input  wire logic       act_event,
    output logic      [7:0] inact_threshold,
    output logic      [7:0] inact_time,
    output logic            detect_enable,
    // Sensor and sample path
    output logic            sensor_enable,
    output logic            conv_tick,
    output logic            sample_tick,
    output logic            low_power_active,
    output logic      [3:0] rate_code_eff,
    output logic      [3:0] bw_code,
    output logic      [1:0] power_mode
);

    typedef struct packed {
        accel_pm_pkg::mode_t mode;
        logic [7:0]          thresh;
        logic [7:0]          itime;
        logic [7:0]          rate;
        logic [7:0]          power;
        logic [7:0]          rd_data;
        logic                rd_valid;
        logic [3:0]          eff_code;
        logic [3:0]          bw_code;
        logic                lp_active;
    } ctl_state_t;

    ctl_state_t q;
    ctl_state_t d;
    logic       measure_on;
    logic       auto_sleep_on;
    logic       run;
    logic [3:0] sel;

    // Codes under 6.25 Hz are undefined; run them at the slowest rate
    function automatic logic [3:0] clamp_code(input logic [3:0] code);
        clamp_code = (code < accel_pm_pkg::RATE_CODE_MIN) ?
                     accel_pm_pkg::RATE_CODE_MIN : code;
    endfunction

    // One-hot select shared by the read mux and the write path, so
    // both always agree on which addresses are mapped
    function automatic logic [3:0] reg_select(input logic [7:0] addr);
        unique case (addr)
            accel_pm_pkg::INACT_THRESH_ADDR: reg_select = 4'h1;
            accel_pm_pkg::INACT_TIME_ADDR:   reg_select = 4'h2;
            accel_pm_pkg::RATE_CTL_ADDR:     reg_select = 4'h4;
            accel_pm_pkg::POWER_STATE_ADDR:  reg_select = 4'h8;
            default:                         reg_select = 4'h0;
        endcase
    endfunction

    // Low power pays only from 12.5 Hz to 400 Hz; outside that window
    // the stored bit has no effect
    function automatic logic lp_window(input logic [3:0] code);
        lp_window = (code >= accel_pm_pkg::LP_CODE_MIN) &&
                    (code <= accel_pm_pkg::LP_CODE_MAX);
    endfunction

    // True in every mode that samples
    function automatic logic mode_runs(input accel_pm_pkg::mode_t m);
        mode_runs = (m != accel_pm_pkg::MODE_STANDBY);
    endfunction

    assign measure_on    = q.power[accel_pm_pkg::MEASURE_BIT];
    assign sel           = reg_select(reg_addr);
    assign auto_sleep_on = q.power[accel_pm_pkg::AUTO_SLEEP_BIT] &
                           q.power[accel_pm_pkg::LINK_BIT];

    // ==========================================================
    // Register access and mode control
    always_comb begin
        d          = q;
        d.rd_valid = reg_rd_en;
        d.rd_data  = 8'h00;
        // Access is open in every mode, standby included
        // Writes stay open outside standby too; the host is expected
        // to finish configuring before it sets the measure bit
        if (reg_rd_en) begin
            d.rd_data = ({8{sel[0]}} & q.thresh) |
                        ({8{sel[1]}} & q.itime)  |
                        ({8{sel[2]}} & q.rate)   |
                        ({8{sel[3]}} & q.power);
        end
        if (reg_wr_en && sel[0]) begin
            d.thresh = reg_wr_data;
        end
        if (reg_wr_en && sel[1]) begin
            d.itime = reg_wr_data;
        end
        if (reg_wr_en && sel[2]) begin
            d.rate = reg_wr_data;
        end
        if (reg_wr_en && sel[3]) begin
            d.power = reg_wr_data;
        end

        // ==========================================================
        // Mode sequencing
        unique case (q.mode)
            accel_pm_pkg::MODE_STANDBY: begin
                if (measure_on) begin
                    d.mode = accel_pm_pkg::MODE_MEASURE;
                end
            end
            accel_pm_pkg::MODE_MEASURE: begin
                if (!measure_on) begin
                    d.mode = accel_pm_pkg::MODE_STANDBY;
                end else if (auto_sleep_on && inact_event) begin
                    d.mode = accel_pm_pkg::MODE_SLEEP;
                end
            end
            accel_pm_pkg::MODE_SLEEP: begin
                if (!measure_on) begin
                    d.mode = accel_pm_pkg::MODE_STANDBY;
                end else if (act_event || !auto_sleep_on) begin
                    d.mode = accel_pm_pkg::MODE_MEASURE;
                end
            end
            default: begin
                // Code 11 is never entered; fall back to standby
                d.mode = accel_pm_pkg::MODE_STANDBY;
            end
        endcase

        // ==========================================================
        // Rate and sampling selection
        // Sleep runs at the slowest code, under 8 Hz
        if (q.mode == accel_pm_pkg::MODE_SLEEP) begin
            d.eff_code = accel_pm_pkg::SLEEP_CODE;
        end else begin
            d.eff_code = clamp_code(q.rate[3:0]);
        end
        // Bandwidth equals the rate one code lower
        d.bw_code = q.eff_code - 4'h1;
        // Low power only where it pays: 12.5 Hz to 400 Hz
        d.lp_active = q.rate[accel_pm_pkg::LOW_POWER_BIT] &&
                      lp_window(q.eff_code) &&
                      mode_runs(q.mode);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            q          <= '0;
            q.mode     <= accel_pm_pkg::MODE_STANDBY;
            q.thresh   <= accel_pm_pkg::INACT_THRESH_RST;
            q.itime    <= accel_pm_pkg::INACT_TIME_RST;
            q.rate     <= accel_pm_pkg::RATE_CTL_RST;
            q.power    <= accel_pm_pkg::POWER_STATE_RST;
            q.eff_code <= accel_pm_pkg::RATE_CODE_MIN;
            q.bw_code  <= accel_pm_pkg::RATE_CODE_MIN - 4'h1;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Sample timing
    // Ticks stop in standby; nothing here clears the sample buffer
    assign run = mode_runs(q.mode);

    sample_tick_gen #(
        .BASE_PERIOD (BASE_PERIOD),
        .CW          (CW)
    ) u_ticks (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .run         (run),
        .rate_code   (q.eff_code),
        .low_power   (q.lp_active),
        .odr_tick    (sample_tick),
        .conv_tick   (conv_tick)
    );

    // ==========================================================
    // Outputs
    assign reg_rd_data      = q.rd_data;
    assign reg_rd_valid     = q.rd_valid;
    assign inact_threshold  = q.thresh;
    assign inact_time       = q.itime;
    // Detector and sensor share one enable: both idle in standby
    assign detect_enable    = run;
    assign sensor_enable    = run;
    assign low_power_active = q.lp_active;
    assign rate_code_eff    = q.eff_code;
    assign bw_code          = q.bw_code;
    assign power_mode       = q.mode;
    // Sample buffer is written only by sample_tick, never flushed
    // here, so its contents survive standby

endmodule

// ---- inc/accel_pm_pkg.sv ----
package accel_pm_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] INACT_THRESH_ADDR = 8'h25;
    localparam logic [7:0] INACT_TIME_ADDR   = 8'h26;
    localparam logic [7:0] RATE_CTL_ADDR     = 8'h2c;
    localparam logic [7:0] POWER_STATE_ADDR  = 8'h2d;

    // ==========================================================
    // Field positions
    localparam int LOW_POWER_BIT  = 4;
    localparam int MEASURE_BIT    = 3;
    localparam int AUTO_SLEEP_BIT = 4;
    localparam int LINK_BIT       = 5;

    // ==========================================================
    // Reset values
    localparam logic [7:0] INACT_THRESH_RST = 8'h00;
    localparam logic [7:0] INACT_TIME_RST   = 8'h00;
    localparam logic [7:0] RATE_CTL_RST     = 8'h0a;
    localparam logic [7:0] POWER_STATE_RST  = 8'h00;

    // ==========================================================
    // Rate codes
    localparam logic [3:0] RATE_CODE_MAX = 4'hf;
    localparam logic [3:0] RATE_CODE_MIN = 4'h6;
    localparam logic [3:0] SLEEP_CODE    = 4'h6;
    localparam logic [3:0] LP_CODE_MIN   = 4'h7;
    localparam logic [3:0] LP_CODE_MAX   = 4'hc;

    // ==========================================================
    // Timing
    localparam int CLK_HZ          = 10_000_000;
    localparam int TOP_RATE_HZ     = 3200;
    localparam int BASE_PERIOD_CYC = CLK_HZ / TOP_RATE_HZ;
    localparam logic [1:0] OVS_SHIFT_NORMAL = 2'h2;
    localparam logic [1:0] OVS_SHIFT_LOW    = 2'h1;

    // ==========================================================
    // Power modes
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_MEASURE = 2'b01,
        MODE_SLEEP   = 2'b10
    } mode_t;

endpackage

// ---- logic/sample_tick_gen.sv ----
`timescale 1ns/10ps
module sample_tick_gen #(
    parameter int BASE_PERIOD = accel_pm_pkg::BASE_PERIOD_CYC,
    parameter int CW          = 24
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Control
    input  wire logic       run,
    input  wire logic [3:0] rate_code,
    input  wire logic       low_power,
    // Strobes
    output logic            odr_tick,
    output logic            conv_tick
);

    typedef struct packed {
        logic [CW-1:0] cnt_odr;
        logic [CW-1:0] cnt_conv;
        logic          odr_tick;
        logic          conv_tick;
    } tick_state_t;

    tick_state_t q;
    tick_state_t d;
    logic [CW-1:0] odr_period;
    logic [CW-1:0] conv_period;

    // ==========================================================
    // Period arithmetic
    always_comb begin
        // Each code step below the top halves the rate
        odr_period  = CW'(BASE_PERIOD) << (accel_pm_pkg::RATE_CODE_MAX
                                           - rate_code);
        conv_period = odr_period >> (low_power ?
                                     accel_pm_pkg::OVS_SHIFT_LOW :
                                     accel_pm_pkg::OVS_SHIFT_NORMAL);
    end

    // ==========================================================
    // Counters
    always_comb begin
        d           = q;
        d.odr_tick  = 1'b0;
        d.conv_tick = 1'b0;
        if (!run) begin
            d.cnt_odr  = '0;
            d.cnt_conv = '0;
        end else begin
            if (q.cnt_odr >= odr_period - 1'b1) begin
                d.cnt_odr  = '0;
                d.odr_tick = 1'b1;
            end else begin
                d.cnt_odr = q.cnt_odr + 1'b1;
            end
            if (q.cnt_conv >= conv_period - 1'b1) begin
                d.cnt_conv  = '0;
                d.conv_tick = 1'b1;
            end else begin
                d.cnt_conv = q.cnt_conv + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign odr_tick  = q.odr_tick;
    assign conv_tick = q.conv_tick;

endmodule

// ---- verif/accel_pm_monitor.sv ----
`timescale 1ns/10ps
module accel_pm_monitor (
    // Clock and reset
    input logic       core_clk,
    input logic       reset_n,
    // Register port
    input logic       reg_wr_en,
    input logic       reg_rd_en,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wr_data,
    input logic       reg_rd_valid,
    // Detector and sample path
    input logic       inact_event,
    input logic       act_event,
    input logic       detect_enable,
    input logic       sensor_enable,
    input logic       conv_tick,
    input logic       sample_tick,
    input logic [3:0] rate_code_eff,
    input logic [1:0] power_mode
);
    // ==========================================
    // Read answer, mode sequencing, sleep rate, enable and standby sampling checks
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_pwr_wr;
        reg_wr_en && reg_addr == accel_pm_pkg::POWER_STATE_ADDR;
    endsequence
    sequence s_sleep_held;
        (power_mode == 2'b10) [*2];
    endsequence
    AST_RD_ANSWER: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read not answered");
    AST_MEAS_ON: assert property (s_pwr_wr ##0 reg_wr_data[3]
        && power_mode == 2'b00 |-> ##2 power_mode == 2'b01)
        else $error("measure not entered");
    AST_MEAS_OFF: assert property (s_pwr_wr ##0 !reg_wr_data[3]
        |-> ##2 power_mode == 2'b00)
        else $error("standby not entered");
    AST_SLEEP_CAUSE: assert property (power_mode == 2'b10
        && $past(power_mode) == 2'b01 |-> $past(inact_event))
        else $error("sleep without inactivity");
    AST_WAKE: assert property (power_mode == 2'b10 && act_event
        && !$past(reg_wr_en) |=> power_mode == 2'b01)
        else $error("no wake on activity");
    AST_SLEEP_RATE: assert property (s_sleep_held
        |-> rate_code_eff == 4'h6)
        else $error("sleep rate wrong");
    AST_SENSE: assert property (sensor_enable == (power_mode != 2'b00)
        && detect_enable == sensor_enable)
        else $error("sensor enable wrong");
    AST_IDLE: assert property ((power_mode == 2'b00) [*2]
        |-> !sample_tick && !conv_tick)
        else $error("sampling in standby");
endmodule
bind accel_power_mode_control accel_pm_monitor mon_u (
    .core_clk(core_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_valid(reg_rd_valid), .inact_event(inact_event),
    .act_event(act_event), .detect_enable(detect_enable),
    .sensor_enable(sensor_enable), .conv_tick(conv_tick),
    .sample_tick(sample_tick), .rate_code_eff(rate_code_eff),
    .power_mode(power_mode)
);

// ---- verif/host_model.sv ----
`timescale 1ns/10ps
module host_model (
    // Clock
    input  logic       core_clk,
    // Register port
    output logic       reg_wr_en,
    output logic       reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wr_data,
    input  logic [7:0] reg_rd_data,
    input  logic       reg_rd_valid
);
    // ==========================================
    // Register cycles, idle lines show inverted data
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wr_data = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wr_data <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [8:0] d);
        @(posedge core_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        @(posedge core_clk);
        d = {reg_rd_valid, reg_rd_data};
    endtask
endmodule

// ---- verif/accel_power_mode_control_tb_top.sv ----
`timescale 1ns/10ps
module accel_power_mode_control_tb_top;
    logic       core_clk, reset_n, reg_wr_en, reg_rd_en, reg_rd_valid;
    logic       inact_event, act_event, detect_enable, sensor_enable;
    logic       conv_tick, sample_tick, low_power_active;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, thr, tim;
    logic [3:0] rate_code_eff, bw_code;
    logic [1:0] power_mode;
    logic [8:0] rv;
    int         bad_count, compares, n;
    accel_power_mode_control #(.BASE_PERIOD(4)) dut_u (
        .core_clk(core_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .inact_event(inact_event),
        .act_event(act_event), .inact_threshold(thr), .inact_time(tim),
        .detect_enable(detect_enable), .sensor_enable(sensor_enable),
        .conv_tick(conv_tick), .sample_tick(sample_tick),
        .low_power_active(low_power_active),
        .rate_code_eff(rate_code_eff), .bw_code(bw_code),
        .power_mode(power_mode)
    );
    host_model host_u (
        .core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid)
    );
    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;
    // ==========================================
    // Helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Cycles up to the next conversion or sample strobe
    task automatic gap(input bit cv, output int c);
        c = 0;
        do begin
            @(posedge core_clk);
            c++;
        end while ((cv ? conv_tick : sample_tick) !== 1'b1 && c < 5000);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_config;
        check({power_mode, sensor_enable}, 3'b000);
        host_u.rd(accel_pm_pkg::RATE_CTL_ADDR, rv);
        check(rv, {1'b1, accel_pm_pkg::RATE_CTL_RST});
        host_u.wr(accel_pm_pkg::INACT_THRESH_ADDR, 8'h5a);
        host_u.wr(accel_pm_pkg::INACT_TIME_ADDR, 8'ha5);
        host_u.rd(accel_pm_pkg::INACT_TIME_ADDR, rv);
        check(rv, 9'h1a5);
        check({thr, tim}, 16'h5aa5);
        host_u.rd(8'h2e, rv);
        check(rv, 9'h100);
        check(power_mode, 2'b00);
    endtask
    task automatic t_rates;
        int p;
        bit lp;
        host_u.wr(accel_pm_pkg::POWER_STATE_ADDR, 8'h38);
        repeat (3) @(posedge core_clk);
        check({power_mode, sensor_enable, detect_enable}, 4'h7);
        for (int c = 6; c <= 15; c++) begin
            p = 4 << (15 - c);
            lp = c >= 7 && c <= 12;
            host_u.wr(accel_pm_pkg::RATE_CTL_ADDR, 8'h10 | 8'(c));
            gap(0, n);
            gap(0, n);
            gap(0, n);
            check(n, p);
            check({rate_code_eff, bw_code}, {4'(c), 4'(c - 1)});
            check(low_power_active, lp);
            gap(1, n);
            gap(1, n);
            check(n, p >> (lp ? 1 : 2));
        end
        host_u.wr(accel_pm_pkg::RATE_CTL_ADDR, 8'h03);
        repeat (3) @(posedge core_clk);
        check({rate_code_eff, bw_code, low_power_active}, 9'h0ca);
    endtask
    task automatic t_sleep;
        host_u.wr(accel_pm_pkg::RATE_CTL_ADDR, 8'h1a);
        repeat (3) @(posedge core_clk);
        inact_event <= 1'b1;
        @(posedge core_clk) inact_event <= 1'b0;
        repeat (3) @(posedge core_clk);
        check({power_mode, rate_code_eff, bw_code}, 10'h265);
        check(low_power_active, 1'b0);
        gap(0, n);
        gap(0, n);
        check(n, 4 << 9);
        act_event <= 1'b1;
        @(posedge core_clk) act_event <= 1'b0;
        repeat (3) @(posedge core_clk);
        check({power_mode, rate_code_eff, low_power_active}, 7'h35);
    endtask
    task automatic t_standby;
        host_u.wr(accel_pm_pkg::POWER_STATE_ADDR, 8'h30);
        repeat (3) @(posedge core_clk);
        check({power_mode, sensor_enable}, 3'b000);
        gap(0, n);
        check(n, 5000);
        host_u.rd(accel_pm_pkg::POWER_STATE_ADDR, rv);
        check(rv, 9'h130);
    endtask
    task automatic t_reset;
        host_u.wr(accel_pm_pkg::POWER_STATE_ADDR, 8'h08);
        repeat (3) @(posedge core_clk);
        check(power_mode, 2'b01);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        check({power_mode, rate_code_eff, bw_code}, 10'h065);
        check({thr, tim}, 16'h0000);
        check(sensor_enable, 1'b0);
        reset_n <= 1'b1;
        host_u.rd(accel_pm_pkg::POWER_STATE_ADDR, rv);
        check(rv, 9'h100);
    endtask
    initial begin
        reset_n = 1'b0;
        inact_event = 1'b0;
        act_event = 1'b0;
        bad_count = 0;
        compares = 0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        t_config;
        t_rates;
        t_sleep;
        t_standby;
        t_reset;
        finish_test;
    end
    initial begin
        #5_000_000;
        bad_count++;
        finish_test;
    end
endmodule
